// ### hdl/avc_pkg.sv
package avc_pkg;

    // register addresses on the plain register port
    localparam logic [15:0] ADDR_CONV_CTRL = 16'hFE58;
    localparam logic [15:0] ADDR_CONV_MODE = 16'hFE59;
    localparam logic [15:0] ADDR_RESULT_LO = 16'hFE5A;
    localparam logic [15:0] ADDR_RESULT_HI = 16'hFE5B;
    localparam logic [15:0] ADDR_IRQ_STATUS = 16'hFE5C;
    localparam logic [15:0] ADDR_IRQ_MASK = 16'hFE5D;
    localparam logic [15:0] ADDR_REF_CTRL = 16'hFEC0;
    localparam logic [15:0] ADDR_REF_LOW_TRIM = 16'hFEC1;
    localparam logic [15:0] ADDR_PIN_IN_OFF = 16'hFEC2;
    localparam logic [15:0] ADDR_AMP_CTRL = 16'hFEC3;
    localparam logic [15:0] ADDR_REF_HIGH_TRIM = 16'hFEC6;

    // conversion control register fields
    localparam int CC_CHAN_LSB = 4;
    localparam int CC_RUN_BIT = 2;
    localparam int CC_DONE_BIT = 1;
    localparam int CC_IRQ_EN_BIT = 0;

    // conversion mode and result-low fields
    localparam int MODE_EIGHT_BIT = 6;
    localparam int RLO_TM2_BIT = 0;

    // reference control fields
    localparam int REF_LOW_ON = 7;
    localparam int REF_HIGH_ON = 6;
    localparam int COMP_ON = 5;
    localparam int REF_SRC_SEL = 1;
    localparam int REF_LEVEL_SEL = 0;
    localparam logic [7:0] REF_WR_MASK = 8'hE3;

    // amplifier control fields
    localparam int AMP_ON = 7;
    localparam int AMP_GAIN20 = 6;
    localparam logic [7:0] AMP_WR_MASK = 8'hD7;

    // interrupt status bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ABORT = 1;
    localparam int IRQ_BITS = 2;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;

    // conversion time in units of one third of an instruction cycle
    localparam int UNITS_12 = 52;
    localparam int UNITS_8 = 32;
    localparam int UNITS_EXTRA = 2;
    localparam int CNT_W = 24;
    localparam logic [15:0] CONV_VECTOR = 16'h0043;

endpackage

// ### hdl/avc_seq_if.sv
`timescale 1ns/100ps
`default_nettype none

// links the register logic to the conversion timer
interface avc_seq_if;
    logic go;
    logic stop;
    logic eightBit;
    logic [2:0] timeSel;
    logic doubleTime;
    logic busy;
    logic finish;

    modport ctrl (output go, stop, eightBit, timeSel, doubleTime, input busy, finish);
    modport timer (input go, stop, eightBit, timeSel, doubleTime, output busy, finish);
endinterface

`default_nettype wire

// ### hdl/avc_conv_timer.sv
`timescale 1ns/100ps
`default_nettype none

module avc_conv_timer
    import avc_pkg::*;
#(
    parameter int CYC_PER_UNIT = 1
) (
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset
    avc_seq_if.timer seq // control from the register side
);

    logic [CNT_W-1:0] units;
    logic [CNT_W-1:0] total;
    logic [CNT_W-1:0] remain;
    logic busy;

    // conversion length, latched only when a conversion starts
    always_comb begin
        units = (seq.eightBit ? CNT_W'(UNITS_8) : CNT_W'(UNITS_12)) << seq.timeSel;
        units = units + CNT_W'(UNITS_EXTRA);
        // R5 doubled first time
        if (seq.doubleTime) begin
            units = units << 1;
        end
        total = units * CNT_W'(CYC_PER_UNIT);
    end

    // busy state; an abort wins over a finish in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            busy <= 1'b0;
        // R1 abort on stop
        end else if (seq.stop) begin
            busy <= 1'b0;
        end else if (seq.go && !busy) begin
            busy <= 1'b1;
        end else if (seq.finish) begin
            busy <= 1'b0;
        end
    end

    // down counter of remaining cycles
    always_ff @(posedge clk) begin
        if (rst) begin
            remain <= '0;
        end else if (seq.go && !busy) begin
            remain <= total - CNT_W'(1);
        end else if (busy && remain != '0) begin
            remain <= remain - CNT_W'(1);
        end
    end

    assign seq.busy = busy;
    assign seq.finish = busy && (remain == '0) && !seq.stop;

endmodule

`default_nettype wire

// ### hdl/avc_adc_vref_ctrl.sv
// Overview of operation
// R1 - writing run bit zero aborts conversion
// R2 - reset clears run bit, halts converter
// R3 - completion sets done, clears run together
// R4 - done with irq enable requests interrupt
// R5 - first twelve-bit conversion after reset doubled
// R6 - first twelve-bit after eight-bit switch doubled
// R7 - otherwise normal conversion time
// R8 - software stops conversion before standby
// R9 - bit 7 switches low reference
// R10 - bit 6 switches high reference
// R11 - comparator needs its enable and low reference
// R12 - comparator high while pin below threshold
// R13 - high reference drives selected level
// R14 - select zero: high off, supply reference
// R15 - register disables analog pin digital inputs
// R16 - low four bits used, upper are test
// R17 - amplifier needs its enable and low reference
// R18 - software clears done flag by write
// R19 - trim registers drive trim outputs
`timescale 1ns/100ps
`default_nettype none

module avc_adc_vref_ctrl
    import avc_pkg::*;
#(
    parameter int CYC_PER_UNIT = 1
) (
    input wire logic clk, // system clock, 100 MHz
    input wire logic rst, // synchronous reset, active high
    input wire logic [15:0] regAddr, // register address
    input wire logic [7:0] regWrData, // register write data
    input wire logic regWr, // write strobe
    input wire logic regRd, // read strobe
    output logic [7:0] regRdData, // read data, cycle after strobe
    output logic irq, // unmasked status interrupt
    output logic convIrqReq, // request to conversion vector
    input wire logic [11:0] adcResultIn, // converter result bits
    input wire logic compBelowIn, // comparator pin below threshold
    output logic convActive, // converter running
    output logic [3:0] chanSel, // converter input select
    output logic refLowBlockOn, // low reference block on
    output logic refHighBlockOn, // high reference block on
    output logic refLevelHigh, // high reference at upper level
    output logic vrefPinDrive, // reference pin driven
    output logic adcRefFromPin, // converter uses reference pin
    output logic comparatorRun, // comparator running
    output logic comparatorOut, // comparator result
    output logic amplifierRun, // amplifier running
    output logic ampGain20, // amplifier high gain
    output logic [2:0] ampInputSel, // amplifier input switches
    output logic [3:0] pinDigitalInOff, // digital input disables
    output logic [7:0] refLowTrim, // low reference trim
    output logic [7:0] refHighTrim // high reference trim
);

    avc_seq_if seq ();

    logic runBit;
    logic doneFlag;
    logic irqEnable;
    logic [3:0] chanField;
    logic eightBit;
    logic [1:0] timeLow;
    logic timeTop;
    logic firstTwelve;
    logic [7:0] resultHigh;
    logic [3:0] resultLow;
    logic [IRQ_BITS-1:0] irqStatus;
    logic [IRQ_BITS-1:0] irqMask;
    logic [IRQ_BITS-1:0] irqEvents;
    logic [7:0] refCtrl;
    logic [7:0] lowTrim;
    logic [7:0] highTrim;
    logic [7:0] pinOff;
    logic [7:0] ampCtrl;
    logic wrConvCtrl;
    logic wrConvMode;
    logic wrResultLo;
    logic rdStatus;

    // write decode; unmapped writes fall through unseen
    assign wrConvCtrl = regWr && (regAddr == ADDR_CONV_CTRL);
    assign wrConvMode = regWr && (regAddr == ADDR_CONV_MODE);
    assign wrResultLo = regWr && (regAddr == ADDR_RESULT_LO);
    assign rdStatus = regRd && (regAddr == ADDR_IRQ_STATUS);

    // start only from idle; a write of one while running does not restart the timer
    assign seq.go = wrConvCtrl && regWrData[CC_RUN_BIT] && !runBit;
    // R1 clearing run aborts
    assign seq.stop = wrConvCtrl && !regWrData[CC_RUN_BIT] && runBit;
    assign seq.eightBit = eightBit;
    assign seq.timeSel = {timeTop, timeLow};
    // R7 normal time otherwise
    assign seq.doubleTime = firstTwelve && !eightBit;

    avc_conv_timer #(
        .CYC_PER_UNIT(CYC_PER_UNIT)
    ) u_timer (
        .clk(clk),
        .rst(rst),
        .seq(seq)
    );

    // run bit: set by software, dropped by completion or abort
    always_ff @(posedge clk) begin
        // R2 reset halts run
        if (rst) begin
            runBit <= 1'b0;
        // R3 completion clears run
        end else if (seq.finish) begin
            runBit <= 1'b0;
        end else if (wrConvCtrl) begin
            runBit <= regWrData[CC_RUN_BIT];
        end
    end

    // done flag: hardware sets, software clears; the set wins a tie
    always_ff @(posedge clk) begin
        if (rst) begin
            doneFlag <= 1'b0;
        // R3 completion sets done
        end else if (seq.finish) begin
            doneFlag <= 1'b1;
        // R18 cleared by write
        end else if (wrConvCtrl) begin
            doneFlag <= doneFlag & regWrData[CC_DONE_BIT];
        end
    end

    // channel select and interrupt enable fields
    always_ff @(posedge clk) begin
        if (rst) begin
            irqEnable <= 1'b0;
            chanField <= 4'h0;
        end else if (wrConvCtrl) begin
            irqEnable <= regWrData[CC_IRQ_EN_BIT];
            chanField <= regWrData[CC_CHAN_LSB +: 4];
        end
    end

    // resolution and time division fields
    always_ff @(posedge clk) begin
        if (rst) begin
            eightBit <= 1'b0;
            timeLow <= 2'h0;
        end else if (wrConvMode) begin
            eightBit <= regWrData[MODE_EIGHT_BIT];
            timeLow <= regWrData[1:0];
        end
    end

    // top time division bit shares the result-low register
    always_ff @(posedge clk) begin
        if (rst) begin
            timeTop <= 1'b0;
        end else if (wrResultLo) begin
            timeTop <= regWrData[RLO_TM2_BIT];
        end
    end

    // first-conversion marker; only a finished twelve-bit run retires it,
    // so an aborted first conversion still gets the long time next go
    always_ff @(posedge clk) begin
        // R5 armed by reset
        if (rst) begin
            firstTwelve <= 1'b1;
        // R6 armed by mode switch
        end else if (wrConvMode && eightBit && !regWrData[MODE_EIGHT_BIT]) begin
            firstTwelve <= 1'b1;
        end else if (seq.finish && !eightBit) begin
            firstTwelve <= 1'b0;
        end
    end

    // result capture; eight-bit mode leaves the low nibble alone
    always_ff @(posedge clk) begin
        if (rst) begin
            resultHigh <= RST_BYTE;
            resultLow <= 4'h0;
        end else if (seq.finish) begin
            resultHigh <= adcResultIn[11:4];
            if (!eightBit) begin
                resultLow <= adcResultIn[3:0];
            end
        end
    end

    // events for the status register
    assign irqEvents[IRQ_DONE] = seq.finish;
    assign irqEvents[IRQ_ABORT] = seq.stop;

    // sticky status, cleared by reading it; a new event beats the clear
    always_ff @(posedge clk) begin
        if (rst) begin
            irqStatus <= '0;
        end else if (rdStatus) begin
            irqStatus <= irqEvents;
        end else begin
            irqStatus <= irqStatus | irqEvents;
        end
    end

    // interrupt mask
    always_ff @(posedge clk) begin
        if (rst) begin
            irqMask <= '0;
        end else if (regWr && (regAddr == ADDR_IRQ_MASK)) begin
            irqMask <= regWrData[IRQ_BITS-1:0];
        end
    end

    // reference control, reserved bits kept at zero
    always_ff @(posedge clk) begin
        if (rst) begin
            refCtrl <= RST_BYTE;
        end else if (regWr && (regAddr == ADDR_REF_CTRL)) begin
            refCtrl <= regWrData & REF_WR_MASK;
        end
    end

    // trim registers, no decode beyond the address
    always_ff @(posedge clk) begin
        if (rst) begin
            lowTrim <= RST_BYTE;
            highTrim <= RST_BYTE;
        end else if (regWr) begin
            // R19 trim store
            if (regAddr == ADDR_REF_LOW_TRIM) begin
                lowTrim <= regWrData;
            end
            if (regAddr == ADDR_REF_HIGH_TRIM) begin
                highTrim <= regWrData;
            end
        end
    end

    // digital input disable; test bits are stored but drive nothing
    always_ff @(posedge clk) begin
        if (rst) begin
            pinOff <= RST_BYTE;
        // R15 input disable register
        end else if (regWr && (regAddr == ADDR_PIN_IN_OFF)) begin
            pinOff <= regWrData;
        end
    end

    // amplifier control, reserved bits 5 and 3 kept at zero, bit 4 stored
    always_ff @(posedge clk) begin
        if (rst) begin
            ampCtrl <= RST_BYTE;
        end else if (regWr && (regAddr == ADDR_AMP_CTRL)) begin
            ampCtrl <= regWrData & AMP_WR_MASK;
        end
    end

    // read port; data stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            regRdData <= RST_BYTE;
        end else if (regRd) begin
            unique case (regAddr)
                ADDR_CONV_CTRL: begin
                    regRdData <= {chanField, 1'b0, runBit, doneFlag, irqEnable};
                end
                ADDR_CONV_MODE: begin
                    regRdData <= {1'b0, eightBit, 4'h0, timeLow};
                end
                ADDR_RESULT_LO: begin
                    regRdData <= {resultLow, 3'h0, timeTop};
                end
                ADDR_RESULT_HI: begin
                    regRdData <= resultHigh;
                end
                ADDR_IRQ_STATUS: begin
                    regRdData <= {6'h00, irqStatus};
                end
                ADDR_IRQ_MASK: begin
                    regRdData <= {6'h00, irqMask};
                end
                ADDR_REF_CTRL: begin
                    regRdData <= refCtrl;
                end
                ADDR_REF_LOW_TRIM: begin
                    regRdData <= lowTrim;
                end
                ADDR_PIN_IN_OFF: begin
                    regRdData <= pinOff;
                end
                ADDR_AMP_CTRL: begin
                    regRdData <= ampCtrl;
                end
                ADDR_REF_HIGH_TRIM: begin
                    regRdData <= highTrim;
                end
                default: begin
                    regRdData <= RST_BYTE;
                end
            endcase
        end else begin
            regRdData <= RST_BYTE;
        end
    end

    // interrupt outputs, both levels
    assign irq = |(irqStatus & irqMask);
    // R4 done requests vector
    assign convIrqReq = doneFlag & irqEnable;

    // converter status straight from the timer and the control field
    assign convActive = seq.busy;
    assign chanSel = chanField;

    // reference block controls, registered so the analog side sees clean levels
    always_ff @(posedge clk) begin
        if (rst) begin
            refLowBlockOn <= 1'b0;
            refHighBlockOn <= 1'b0;
            refLevelHigh <= 1'b0;
            vrefPinDrive <= 1'b0;
            adcRefFromPin <= 1'b0;
        end else begin
            // R9 low reference enable
            refLowBlockOn <= refCtrl[REF_LOW_ON];
            // R10 high reference enable
            // R13 high block drives
            // R14 select zero off
            refHighBlockOn <= refCtrl[REF_LOW_ON] & refCtrl[REF_HIGH_ON]
                & refCtrl[REF_SRC_SEL];
            vrefPinDrive <= refCtrl[REF_LOW_ON] & refCtrl[REF_HIGH_ON]
                & refCtrl[REF_SRC_SEL];
            refLevelHigh <= refCtrl[REF_LEVEL_SEL];
            // R14 supply reference
            adcRefFromPin <= refCtrl[REF_SRC_SEL];
        end
    end

    // comparator gating; held low while not running
    always_ff @(posedge clk) begin
        if (rst) begin
            comparatorRun <= 1'b0;
            comparatorOut <= 1'b0;
        end else begin
            // R11 comparator gated
            comparatorRun <= refCtrl[COMP_ON] & refCtrl[REF_LOW_ON];
            // R12 high when below
            comparatorOut <= refCtrl[COMP_ON] & refCtrl[REF_LOW_ON] & compBelowIn;
        end
    end

    // amplifier and pin controls
    always_ff @(posedge clk) begin
        if (rst) begin
            amplifierRun <= 1'b0;
            ampGain20 <= 1'b0;
            ampInputSel <= 3'h0;
            pinDigitalInOff <= 4'h0;
            refLowTrim <= RST_BYTE;
            refHighTrim <= RST_BYTE;
        end else begin
            // R17 amplifier gated
            amplifierRun <= ampCtrl[AMP_ON] & refCtrl[REF_LOW_ON];
            ampGain20 <= ampCtrl[AMP_GAIN20];
            ampInputSel <= ampCtrl[2:0];
            // R16 low four bits
            pinDigitalInOff <= pinOff[3:0];
            // R19 trim outputs
            refLowTrim <= lowTrim;
            refHighTrim <= highTrim;
        end
    end

endmodule

`default_nettype wire

// ### test/avc_adc_vref_ctrl_checker.sv
`timescale 1ns/100ps
`default_nettype none

// watches the register port and the analog control outputs of the block
module avc_adc_vref_ctrl_checker
    import avc_pkg::*;
(
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire logic [15:0] regAddr, // address
    input wire logic [7:0] regWrData, // write data
    input wire logic regWr, // write strobe
    input wire logic irq, // status interrupt
    input wire logic convIrqReq, // vector request
    input wire logic compBelowIn, // raw comparator
    input wire logic convActive, // converter busy
    input wire logic refLowBlockOn, // low block
    input wire logic refHighBlockOn, // high block
    input wire logic refLevelHigh, // level select
    input wire logic vrefPinDrive, // pin driven
    input wire logic adcRefFromPin, // source select
    input wire logic comparatorRun, // comparator on
    input wire logic comparatorOut, // comparator result
    input wire logic amplifierRun, // amplifier on
    input wire logic [3:0] pinDigitalInOff, // input disables
    input wire logic [7:0] refLowTrim // low trim
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // register writes; outputs are looked at two edges later, past the output flop
    sequence s_ref_wr;
        regWr && regAddr == ADDR_REF_CTRL;
    endsequence

    property p_abort;
        convActive && regWr && regAddr == ADDR_CONV_CTRL && !regWrData[CC_RUN_BIT] |=> !convActive;
    endproperty
    a_abort: assert property (p_abort) else $error("abort write left converter running");
    property p_reset;
        disable iff (1'b0) rst |=> !convActive && !convIrqReq && !irq;
    endproperty
    a_reset: assert property (p_reset) else $error("reset did not halt converter");
    // a request may only appear at a finish or at a write of the enable
    property p_irq_req;
        $rose(convIrqReq) |-> $fell(convActive) || $past(regWr && regAddr == ADDR_CONV_CTRL);
    endproperty
    a_irq_req: assert property (p_irq_req) else $error("request without completion");
    property p_low_on;
        s_ref_wr |-> ##2 refLowBlockOn == $past(regWrData[REF_LOW_ON], 2);
    endproperty
    a_low_on: assert property (p_low_on) else $error("low block does not follow bit 7");
    property p_high_on;
        s_ref_wr |-> ##2 refHighBlockOn == &{$past(regWrData[7:6], 2), $past(regWrData[1], 2)};
    endproperty
    a_high_on: assert property (p_high_on) else $error("high block state wrong");
    property p_comp_run;
        s_ref_wr |-> ##2 comparatorRun == ($past(regWrData[7], 2) && $past(regWrData[5], 2));
    endproperty
    a_comp_run: assert property (p_comp_run) else $error("comparator run state wrong");
    property p_comp_out;
        comparatorRun && $past(comparatorRun) |-> comparatorOut == $past(compBelowIn);
    endproperty
    a_comp_out: assert property (p_comp_out) else $error("comparator output sense wrong");
    property p_level;
        s_ref_wr |-> ##2 refLevelHigh == $past(regWrData[REF_LEVEL_SEL], 2);
    endproperty
    a_level: assert property (p_level) else $error("level select wrong");
    // the pin is driven only by the high block, and the source follows its select
    property p_pin_open;
        s_ref_wr |-> ##2 vrefPinDrive == &{$past(regWrData[7:6], 2), $past(regWrData[1], 2)}
            && adcRefFromPin == $past(regWrData[REF_SRC_SEL], 2);
    endproperty
    a_pin_open: assert property (p_pin_open) else $error("reference pin not left open");
    property p_pin_off;
        regWr && regAddr == ADDR_PIN_IN_OFF |-> ##2 pinDigitalInOff == $past(regWrData[3:0], 2);
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("input disables wrong");
    // both sides of the gate come from the same reference register state
    property p_amp;
        regWr && regAddr == ADDR_AMP_CTRL |-> ##2 amplifierRun == ($past(regWrData[AMP_ON], 2)
            && refLowBlockOn);
    endproperty
    a_amp: assert property (p_amp) else $error("amplifier runs without low block");
    property p_trim;
        regWr && regAddr == ADDR_REF_LOW_TRIM |-> ##2 refLowTrim == $past(regWrData, 2);
    endproperty
    a_trim: assert property (p_trim) else $error("trim output wrong");
endmodule

bind avc_adc_vref_ctrl avc_adc_vref_ctrl_checker u_chk (.clk, .rst, .regAddr, .regWrData, .regWr,
    .irq, .convIrqReq, .compBelowIn, .convActive, .refLowBlockOn, .refHighBlockOn, .refLevelHigh,
    .vrefPinDrive, .adcRefFromPin, .comparatorRun, .comparatorOut, .amplifierRun,
    .pinDigitalInOff, .refLowTrim);

`default_nettype wire

// ### test/avc_adc_vref_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none

module avc_adc_vref_ctrl_tb
    import avc_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] regAddr = 16'h0000;
    logic [7:0] regWrData = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [11:0] adcResultIn = 12'hABC;
    logic compBelowIn = 1'b0;
    logic [7:0] regRdData, refLowTrim, refHighTrim, v;
    logic irq, convIrqReq, convActive, refLowBlockOn, refHighBlockOn, refLevelHigh, hi;
    logic vrefPinDrive, adcRefFromPin, comparatorRun, comparatorOut, amplifierRun, ampGain20;
    logic [3:0] chanSel, pinDigitalInOff;
    logic [2:0] ampInputSel;
    logic [7:0] refVals [6] = '{8'hC2, 8'hC3, 8'hC0, 8'h43, 8'hFF, 8'hA0};
    int miscompares = 0;
    int samplesChecked = 0;
    int n;

    always #5 clk = ~clk;

    avc_adc_vref_ctrl #(.CYC_PER_UNIT(1)) u_dut (.clk, .rst, .regAddr, .regWrData, .regWr, .regRd,
        .regRdData, .irq, .convIrqReq, .adcResultIn, .compBelowIn, .convActive, .chanSel,
        .refLowBlockOn, .refHighBlockOn, .refLevelHigh, .vrefPinDrive, .adcRefFromPin,
        .comparatorRun, .comparatorOut, .amplifierRun, .ampGain20, .ampInputSel,
        .pinDigitalInOff, .refLowTrim, .refHighTrim);

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // one-cycle strobes launched just after an edge, released after the taking edge
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        chk("read data", regRdData, e);
    endtask

    // lets the registered outputs catch up with the last write
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask

    // starts a conversion and counts edges until the converter drops busy
    task automatic conv(input logic [7:0] ctl, input int cyc);
        wr(ADDR_CONV_CTRL, ctl);
        n = 0;
        #1;
        while (convActive === 1'b1 && n < 10000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("conversion cycles", n[15:0], cyc[15:0]);
    endtask

    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // cuts a hang short; the whole sequence needs well under 10000 cycles
    initial begin
        #300000;
        miscompares++;
        finish_test;
    end

    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(ADDR_PIN_IN_OFF, 8'h00);
        rd(16'hFEC4, 8'h00);
        foreach (refVals[i]) begin
            v = refVals[i];
            hi = v[REF_LOW_ON] & v[REF_HIGH_ON] & v[REF_SRC_SEL];
            wr(ADDR_REF_CTRL, v);
            rd(ADDR_REF_CTRL, v & REF_WR_MASK);
            chk("low block", refLowBlockOn, v[REF_LOW_ON]);
            chk("high block", refHighBlockOn, hi);
            chk("level", refLevelHigh, v[REF_LEVEL_SEL]);
            chk("pin drive", vrefPinDrive, hi);
            chk("ref source", adcRefFromPin, v[REF_SRC_SEL]);
            chk("comp run", comparatorRun, v[REF_LOW_ON] & v[COMP_ON]);
        end
        // comparator follows the pin while running, the last table entry left it on
        for (int i = 1; i >= 0; i--) begin
            @(posedge clk);
            compBelowIn <= i[0];
            settle;
            chk("comp out", comparatorOut, i[0]);
        end
        @(posedge clk);
        compBelowIn <= 1'b1;
        wr(ADDR_REF_CTRL, 8'h20);
        settle;
        chk("comp held", comparatorOut, 1'b0);
        wr(ADDR_AMP_CTRL, 8'hFF);
        rd(ADDR_AMP_CTRL, AMP_WR_MASK);
        chk("amp off", amplifierRun, 1'b0);
        chk("amp switches", {ampGain20, ampInputSel}, 4'hF);
        wr(ADDR_REF_CTRL, 8'h80);
        settle;
        chk("amp on", amplifierRun, 1'b1);
        wr(ADDR_REF_LOW_TRIM, 8'hA5);
        wr(ADDR_REF_HIGH_TRIM, 8'h5A);
        wr(ADDR_PIN_IN_OFF, 8'hFF);
        settle;
        chk("trims", {refLowTrim, refHighTrim}, 16'hA55A);
        chk("input disables", pinDigitalInOff, 4'hF);
        rd(ADDR_PIN_IN_OFF, 8'hFF);
        rd(ADDR_REF_HIGH_TRIM, 8'h5A);
        // first twelve-bit run after reset is doubled; abort interrupt only unmasked
        wr(ADDR_IRQ_MASK, 8'h02);
        conv(8'h05, (UNITS_12 + UNITS_EXTRA) * 2);
        rd(ADDR_CONV_CTRL, 8'h03);
        chk("vector request", convIrqReq, 1'b1);
        chk("irq masked", irq, 1'b0);
        wr(ADDR_IRQ_MASK, 8'h03);
        #1;
        chk("irq", irq, 1'b1);
        rd(ADDR_IRQ_STATUS, 8'h01);
        rd(ADDR_IRQ_STATUS, 8'h00);
        chk("irq cleared", irq, 1'b0);
        rd(ADDR_RESULT_HI, 8'hAB);
        rd(ADDR_RESULT_LO, 8'hC0);
        // a write with the done bit low clears the flag and drops the request
        wr(ADDR_CONV_CTRL, 8'h91);
        rd(ADDR_CONV_CTRL, 8'h91);
        chk("request dropped", convIrqReq, 1'b0);
        chk("channel", chanSel, 4'h9);
        conv(8'h04, UNITS_12 + UNITS_EXTRA);
        chk("no request", convIrqReq, 1'b0);
        wr(ADDR_CONV_MODE, 8'h40);
        conv(8'h04, UNITS_8 + UNITS_EXTRA);
        rd(ADDR_RESULT_LO, 8'hC0);
        wr(ADDR_CONV_MODE, 8'h00);
        conv(8'h04, (UNITS_12 + UNITS_EXTRA) * 2);
        wr(ADDR_RESULT_LO, 8'h01);
        conv(8'h04, (UNITS_12 << 4) + UNITS_EXTRA);
        rd(ADDR_IRQ_STATUS, 8'h01);
        // abort in mid-run: no done, abort status instead
        wr(ADDR_CONV_CTRL, 8'h04);
        repeat (5) @(posedge clk);
        wr(ADDR_CONV_CTRL, 8'h00);
        #1;
        chk("aborted", convActive, 1'b0);
        rd(ADDR_CONV_CTRL, 8'h00);
        rd(ADDR_IRQ_STATUS, 8'h02);
        // reset in mid-run halts the converter and re-arms the doubled time
        wr(ADDR_CONV_CTRL, 8'h04);
        repeat (4) @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("reset halt", convActive, 1'b0);
        rd(ADDR_CONV_CTRL, 8'h00);
        rd(ADDR_REF_CTRL, 8'h00);
        conv(8'h04, (UNITS_12 + UNITS_EXTRA) * 2);
        // run bit must read zero before any standby entry
        rd(ADDR_CONV_CTRL, 8'h02);
        finish_test;
    end
endmodule

`default_nettype wire
